// file: xbus_pkg.sv
package xbus_pkg;

    // ==========================================================
    // bus phases and widths
    localparam int unsigned ADDR_W   = 20;
    localparam int unsigned DATA_W   = 16;
    localparam int unsigned LANE_W   = 8;

    // ==========================================================
    // register map, word aligned
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] CFG_OFS    = 8'h08;
    localparam logic [7:0] CMD_OFS    = 8'h0c;
    localparam logic [7:0] WDATA_OFS  = 8'h10;
    localparam logic [7:0] RDATA_OFS  = 8'h14;

    // ==========================================================
    // control fields
    localparam int unsigned CTRL_SHOW_READ_BIT  = 0;
    localparam int unsigned CTRL_LOWER_DIS_BIT  = 1;
    localparam int unsigned CTRL_UPPER_DIS_BIT  = 2;
    localparam int unsigned CTRL_GPIO_REQ_BIT   = 3;
    localparam logic [3:0]  CTRL_RESET          = 4'h0;

    // command fields
    localparam int unsigned CMD_WRITE_BIT  = 20;
    localparam int unsigned CMD_INTMEM_BIT = 21;
    localparam int unsigned CMD_LOWSEL_BIT = 22;
    localparam int unsigned CMD_UPSEL_BIT  = 23;
    localparam int unsigned CMD_BYTE_LO    = 24;
    localparam int unsigned CMD_BYTE_HI    = 25;

    // ==========================================================
    // strap sampling: three crystal clocks after release
    localparam int unsigned STRAP_DELAY_CYC = 3;

    typedef enum logic [4:0] {
        XBUS_IDLE = 5'b00001,
        XBUS_T1   = 5'b00010,
        XBUS_T2   = 5'b00100,
        XBUS_T3   = 5'b01000,
        XBUS_T4   = 5'b10000
    } xbus_phase_type;

    typedef struct packed {
        logic              write;
        logic              intmem;
        logic              lower_sel;
        logic              upper_sel;
        logic              byte_lo;
        logic              byte_hi;
        logic [ADDR_W-1:0] addr;
    } xbus_cmd_type;

endpackage : xbus_pkg

// file: xbus_pins.sv
// Register access over AHB-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ps
// Functional notes
// - strap low locks status pins normal
// - nonmux address a clock before shared
// - nonmux address floats in hold, reset
// - t1 lower lane carries low address
// - wide: t1 upper lane carries high address
// - write data driven t2 through t4
// - read data captured end of t3
// - show read drives internal data t3,t4
// - lanes float t2-t4 when byte strobe inactive, except show read t3,t4
// - shared lanes float in hold, reset
// - reset config captured at reset release
// - wide variant: sixteen bit data bus
// - narrow variant: eight bit data only
// - narrow: upper address held t1-t4
// - narrow: address-only lane floats hold, reset
// - address phase suppression by strap
// - disable bit drops shared address
// - strap sampled three cycles after release
// - latch strobe pulses with address
module xbus_pins #(
    parameter bit WIDE = 1'b1
) (
    input  wire logic                               hclk,
    input  wire logic                               hresetn,
    input  wire logic                               hsel,
    input  wire logic [31:0]                        haddr,
    input  wire logic [1:0]                         htrans,
    input  wire logic                               hwrite,
    input  wire logic [2:0]                         hsize,
    input  wire logic [31:0]                        hwdata,
    input  wire logic                               hready,
    output logic      [31:0]                        hrdata,
    output logic                                    hreadyout,
    output logic                                    hresp,
    input  wire logic                               bus_hold,
    input  wire logic                               ext_ready,
    input  wire logic                               address_enable_strap,
    input  wire logic                               show_read_strap,
    input  wire logic [15:0]                        intmem_data,
    input  wire logic                               clock_output_primary,
    output logic      [xbus_pkg::ADDR_W-1:0]        nonmux_address_bus,
    output logic                                    nonmux_oe_n,
    input  wire logic [15:0]                        shared_bus_in,
    output logic      [15:0]                        shared_bus_out,
    output logic                                    shared_lo_oe_n,
    output logic                                    shared_hi_oe_n,
    output logic      [7:0]                         upper_address_only_lines,
    output logic                                    upper_addr_oe_n,
    output logic                                    address_latch_strobe,
    output logic                                    low_byte_write_strobe_n,
    output logic                                    high_byte_write_strobe_n,
    output logic                                    status_pins_normal
);

    // ==========================================================
    // ahb slave
    logic                        req_q;
    logic                        req_wr_q;
    logic [7:0]                  req_ofs_q;
    logic [3:0]                  ctrl_q;
    logic [15:0]                 wdata_q;
    logic [15:0]                 rdata_q;
    logic [31:0]                 hrdata_q;
    logic [15:0]                 cfg_q;
    logic                        address_enable_strap_q;
    logic                        show_read_strap_q;
    logic [1:0]                  strap_cnt_q;
    logic                        strap_done_q;
    xbus_pkg::xbus_cmd_type      cmd_q;
    logic                        cmd_pend_q;
    logic                        busy_q;
    xbus_pkg::xbus_phase_type    phase_q;
    logic                        clk_out_q;
    logic                        cfg_done_q;
    logic                        start;
    logic                        addr_phase_on;
    logic                        cmd_accept;
    logic                        cmd_wr_hit;
    logic [4:0]                  status_word;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_q     <= 1'b0;
            req_wr_q  <= 1'b0;
            req_ofs_q <= 8'h00;
        end else begin
            req_q     <= hsel && hready && htrans[1];
            req_wr_q  <= hwrite;
            req_ofs_q <= haddr[7:0];
        end
    end

    // ==========================================================
    // command acceptance
    // command writes while busy are dropped; software polls status
    assign cmd_wr_hit = req_q && req_wr_q && (req_ofs_q == xbus_pkg::CMD_OFS);
    assign cmd_accept = cmd_wr_hit && !cmd_pend_q && !busy_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q  <= xbus_pkg::CTRL_RESET;
            wdata_q <= 16'h0000;
        end else if (req_q && req_wr_q) begin
            case (req_ofs_q)
                xbus_pkg::CTRL_OFS: begin
                    ctrl_q <= hwdata[3:0];
                end
                xbus_pkg::WDATA_OFS: begin
                    wdata_q <= hwdata[15:0];
                end
                default: ;
            endcase
        end
    end

    // fields taken at their own bit positions, not by struct order
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_q <= '0;
        end else if (cmd_accept) begin
            cmd_q.write     <= hwdata[xbus_pkg::CMD_WRITE_BIT];
            cmd_q.intmem    <= hwdata[xbus_pkg::CMD_INTMEM_BIT];
            cmd_q.lower_sel <= hwdata[xbus_pkg::CMD_LOWSEL_BIT];
            cmd_q.upper_sel <= hwdata[xbus_pkg::CMD_UPSEL_BIT];
            cmd_q.byte_lo   <= hwdata[xbus_pkg::CMD_BYTE_LO];
            cmd_q.byte_hi   <= hwdata[xbus_pkg::CMD_BYTE_HI];
            cmd_q.addr      <= hwdata[xbus_pkg::ADDR_W-1:0];
        end
    end

    // start and a new accept cannot coincide: accept needs pending low
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_pend_q <= 1'b0;
        end else if (cmd_accept) begin
            cmd_pend_q <= 1'b1;
        end else if (start) begin
            cmd_pend_q <= 1'b0;
        end
    end

    // ==========================================================
    // read mux
    assign status_word = {status_pins_normal, address_enable_strap_q, show_read_strap_q, cmd_pend_q, busy_q};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0000_0000;
        end else if (hsel && hready && htrans[1] && !hwrite) begin
            case (haddr[7:0])
                xbus_pkg::CTRL_OFS:   hrdata_q <= {28'h0000000, ctrl_q};
                xbus_pkg::STATUS_OFS: hrdata_q <= {27'h0000000, status_word};
                xbus_pkg::CFG_OFS:    hrdata_q <= {16'h0000, cfg_q};
                xbus_pkg::WDATA_OFS:  hrdata_q <= {16'h0000, wdata_q};
                xbus_pkg::RDATA_OFS:  hrdata_q <= {16'h0000, rdata_q};
                default:              hrdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // reset configuration and straps
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_done_q <= 1'b0;
            cfg_q      <= 16'h0000;
        end else if (!cfg_done_q) begin
            cfg_done_q <= 1'b1;
            cfg_q      <= WIDE ? shared_bus_in
                               : {shared_bus_in[15:8], shared_bus_in[7:0]};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            strap_cnt_q  <= 2'd0;
            strap_done_q <= 1'b0;
            address_enable_strap_q       <= 1'b1;
            show_read_strap_q       <= 1'b1;
        end else if (!strap_done_q) begin
            strap_cnt_q <= strap_cnt_q + 2'd1;
            if (strap_cnt_q == 2'(xbus_pkg::STRAP_DELAY_CYC - 1)) begin
                strap_done_q <= 1'b1;
                address_enable_strap_q       <= address_enable_strap;
                show_read_strap_q       <= show_read_strap;
            end
        end
    end

    // gpio reassignment only honoured when the strap was high
    assign status_pins_normal = !address_enable_strap_q || !ctrl_q[xbus_pkg::CTRL_GPIO_REQ_BIT];

    // ==========================================================
    // bus cycle sequencer
    assign start = cmd_pend_q && !busy_q && !bus_hold && strap_done_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_q <= xbus_pkg::XBUS_IDLE;
            busy_q  <= 1'b0;
            rdata_q <= 16'h0000;
        end else begin
            case (phase_q)
                xbus_pkg::XBUS_IDLE: begin
                    if (start) begin
                        phase_q <= xbus_pkg::XBUS_T1;
                        busy_q  <= 1'b1;
                    end
                end
                xbus_pkg::XBUS_T1: phase_q <= xbus_pkg::XBUS_T2;
                xbus_pkg::XBUS_T2: phase_q <= xbus_pkg::XBUS_T3;
                xbus_pkg::XBUS_T3: begin
                    if (ext_ready) begin
                        phase_q <= xbus_pkg::XBUS_T4;
                        if (!cmd_q.write) begin
                            rdata_q <= WIDE ? shared_bus_in
                                            : {8'h00, shared_bus_in[7:0]};
                        end
                    end
                end
                xbus_pkg::XBUS_T4: begin
                    phase_q <= xbus_pkg::XBUS_IDLE;
                    busy_q  <= 1'b0;
                end
                default: phase_q <= xbus_pkg::XBUS_IDLE;
            endcase
        end
    end

    // ==========================================================
    // pin drive
    // nonmux address leads the shared lanes by at least one clock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_out_q          <= 1'b0;
            nonmux_address_bus <= '0;
        end else begin
            clk_out_q <= clock_output_primary;
            // loaded on accept, so it stands at least one clock before t1
            if (cmd_accept) begin
                nonmux_address_bus <= hwdata[xbus_pkg::ADDR_W-1:0];
            end
        end
    end

    assign nonmux_oe_n = bus_hold || !strap_done_q;

    // strap low forces the address phase on regardless of disable bits
    assign addr_phase_on = !address_enable_strap_q ||
        !((cmd_q.lower_sel && ctrl_q[xbus_pkg::CTRL_LOWER_DIS_BIT]) ||
          (cmd_q.upper_sel && ctrl_q[xbus_pkg::CTRL_UPPER_DIS_BIT]));

    logic is_t1;
    logic data_ph;
    logic show_rd;
    assign is_t1   = phase_q == xbus_pkg::XBUS_T1;
    assign data_ph = (phase_q == xbus_pkg::XBUS_T2) || (phase_q == xbus_pkg::XBUS_T3)
                     || (phase_q == xbus_pkg::XBUS_T4);
    assign show_rd = cmd_q.intmem && !cmd_q.write
                     && (!show_read_strap_q || ctrl_q[xbus_pkg::CTRL_SHOW_READ_BIT]);

    assign low_byte_write_strobe_n  = !(data_ph && cmd_q.write && cmd_q.byte_lo);
    assign high_byte_write_strobe_n = !(data_ph && cmd_q.write && cmd_q.byte_hi && WIDE);
    assign address_latch_strobe     = is_t1 && addr_phase_on;

    always_comb begin
        shared_bus_out = 16'h0000;
        if (is_t1) begin
            shared_bus_out = cmd_q.addr[15:0];
        end else if (show_rd) begin
            shared_bus_out = intmem_data;
        end else begin
            shared_bus_out = wdata_q;
        end
    end

    logic lo_drv;
    logic hi_drv;
    logic show_ph;
    assign show_ph = show_rd && ((phase_q == xbus_pkg::XBUS_T3)
                     || (phase_q == xbus_pkg::XBUS_T4));
    assign lo_drv = (is_t1 && addr_phase_on) || show_ph
                    || (data_ph && !low_byte_write_strobe_n);
    assign hi_drv = WIDE && ((is_t1 && addr_phase_on) || show_ph
                    || (data_ph && !high_byte_write_strobe_n));

    assign shared_lo_oe_n = !lo_drv || bus_hold || !strap_done_q;
    assign shared_hi_oe_n = !hi_drv || bus_hold || !strap_done_q;

    assign upper_address_only_lines = cmd_q.addr[15:8];
    assign upper_addr_oe_n = WIDE || !busy_q || bus_hold || !strap_done_q;

endmodule : xbus_pins

// file: xbus_pins_monitor.sv
`timescale 1ns/1ps
// ========================================
// pin checker
module xbus_pins_monitor (
    input wire logic                        hclk,
    input wire logic                        hresetn,
    input wire logic                        bus_hold,
    input wire logic [15:0]                 intmem_data,
    input wire logic [xbus_pkg::ADDR_W-1:0] nonmux_address_bus,
    input wire logic                        nonmux_oe_n,
    input wire logic [15:0]                 shared_bus_out,
    input wire logic                        shared_lo_oe_n,
    input wire logic                        shared_hi_oe_n,
    input wire logic                        upper_addr_oe_n,
    input wire logic                        address_latch_strobe,
    input wire logic                        low_byte_write_strobe_n,
    input wire logic                        high_byte_write_strobe_n
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_ale_low_lane: assert property (
        address_latch_strobe |-> !shared_lo_oe_n
        && shared_bus_out[7:0] == nonmux_address_bus[7:0]) else $error("low lane no address");
    a_ale_high_lane: assert property (
        address_latch_strobe |-> !shared_hi_oe_n
        && shared_bus_out[15:8] == nonmux_address_bus[15:8]) else $error("high lane no address");
    a_nonmux_leads: assert property (
        $rose(address_latch_strobe) |-> $past(!nonmux_oe_n) && $stable(nonmux_address_bus))
        else $error("nonmux address not early");
    a_hold_floats: assert property (
        bus_hold [*2] |-> nonmux_oe_n && shared_lo_oe_n && shared_hi_oe_n && upper_addr_oe_n)
        else $error("bus driven in hold");
    a_ale_one_cycle: assert property (
        address_latch_strobe |=> !address_latch_strobe) else $error("strobe too long");
    a_wdata_steady: assert property (
        !low_byte_write_strobe_n && $past(!low_byte_write_strobe_n)
        |-> !shared_lo_oe_n && $stable(shared_bus_out[7:0])) else $error("write data moved");
    a_hi_lane_float: assert property (
        !low_byte_write_strobe_n && high_byte_write_strobe_n |-> shared_hi_oe_n)
        else $error("high lane driven without strobe");
    a_write_phases: assert property (
        $fell(low_byte_write_strobe_n) |-> !low_byte_write_strobe_n [*3])
        else $error("write shorter than t2..t4");
    a_show_read: assert property (
        !address_latch_strobe && !shared_lo_oe_n && low_byte_write_strobe_n
        |-> shared_bus_out[7:0] == intmem_data[7:0]) else $error("show read data wrong");
    c_ale: cover property (address_latch_strobe);
    c_write: cover property (!low_byte_write_strobe_n);
    c_hold: cover property (bus_hold [*2]);
    c_show: cover property (!shared_lo_oe_n && !address_latch_strobe && low_byte_write_strobe_n);
endmodule : xbus_pins_monitor

bind xbus_pins xbus_pins_monitor mon_u (.hclk, .hresetn, .bus_hold, .intmem_data,
    .nonmux_address_bus, .nonmux_oe_n, .shared_bus_out, .shared_lo_oe_n, .shared_hi_oe_n,
    .upper_addr_oe_n, .address_latch_strobe, .low_byte_write_strobe_n,
    .high_byte_write_strobe_n);

// file: xbus_mem_model.sv
`timescale 1ns/1ps
// ========================================
// external memory on the shared lanes
module xbus_mem_model #(
    parameter logic [15:0] CFG = 16'h3c5a
) (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic [19:0] addr,
    input wire logic [15:0] bus_out,
    input wire logic        lo_oe_n,
    input wire logic        hi_oe_n,
    input wire logic        lo_wr_n,
    input wire logic        hi_wr_n,
    output logic     [15:0] bus_in
);
    logic [15:0] mem [0:15];
    logic [1:0]  cfg_q;
    logic [15:0] drv;
    // config kept past release: sampling edge follows release
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) cfg_q <= 2'h3;
        else if (cfg_q != 2'h0) cfg_q <= cfg_q - 2'h1;
    end
    always_ff @(posedge hclk) begin
        if (!lo_wr_n) mem[addr[3:0]][7:0] <= bus_out[7:0];
        if (!hi_wr_n) mem[addr[3:0]][15:8] <= bus_out[15:8];
    end
    assign drv = (cfg_q != 2'h0) ? CFG : mem[addr[3:0]];
    assign bus_in = {hi_oe_n ? drv[15:8] : bus_out[15:8], lo_oe_n ? drv[7:0] : bus_out[7:0]};
endmodule : xbus_mem_model

// file: testbench.sv
`timescale 1ns/1ps
// ========================================
// bench
module testbench;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, bus_hold, ext_ready;
    logic        address_enable_strap, show_read_strap, clock_output_primary, nonmux_oe_n;
    logic        shared_lo_oe_n, shared_hi_oe_n, upper_addr_oe_n, address_latch_strobe;
    logic        low_byte_write_strobe_n, high_byte_write_strobe_n, status_pins_normal;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [15:0] intmem_data, shared_bus_in, shared_bus_out;
    logic [19:0] nonmux_address_bus;
    logic [7:0]  upper_address_only_lines;
    int          mismatches, comparisons, ale_cnt;
    localparam logic [31:0] WR = 32'h1 << xbus_pkg::CMD_WRITE_BIT;
    localparam logic [31:0] IM = 32'h1 << xbus_pkg::CMD_INTMEM_BIT;
    localparam logic [31:0] LS = 32'h1 << xbus_pkg::CMD_LOWSEL_BIT;
    localparam logic [31:0] LO = 32'h1 << xbus_pkg::CMD_BYTE_LO;
    localparam logic [31:0] BB = LO | (32'h1 << xbus_pkg::CMD_BYTE_HI) | 32'h5;
    xbus_pins dut_u (.*);
    xbus_mem_model pm_u (.hclk, .hresetn, .addr(nonmux_address_bus), .bus_out(shared_bus_out),
        .lo_oe_n(shared_lo_oe_n), .hi_oe_n(shared_hi_oe_n), .lo_wr_n(low_byte_write_strobe_n),
        .hi_wr_n(high_byte_write_strobe_n), .bus_in(shared_bus_in));
    assign hready = hreadyout;
    always #4 hclk = ~hclk;
    always @(posedge hclk) if (address_latch_strobe === 1'b1) ale_cnt++;
    task automatic report_and_stop;
        if (mismatches == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1) begin
            mismatches++;
            report_and_stop;
        end
    endtask : wait_rdy
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h0, a};
        wait_rdy;
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy;
        q = hrdata;
    endtask : xfer
    task automatic run_cmd(input logic [31:0] c);
        int n;
        xfer(1'b1, xbus_pkg::CMD_OFS, c);
        n = 0;
        do begin
            xfer(1'b0, xbus_pkg::STATUS_OFS, 32'h0);
            n++;
        end while (q[1:0] !== 2'b00 && n < 200);
        chk({30'h0, q[1:0]}, 32'h0);
    endtask : run_cmd
    task automatic do_reset;
        hresetn <= 1'b0;
        repeat (11) @(posedge hclk);
        chk({nonmux_oe_n, shared_lo_oe_n, shared_hi_oe_n, upper_addr_oe_n}, 32'hf);
        @(posedge hclk);
        hresetn <= 1'b1;
        repeat (4) @(posedge hclk);
    endtask : do_reset
    initial begin
        {hclk, hresetn, hsel, hwrite, htrans, haddr, hwdata, bus_hold} = '0;
        {mismatches, comparisons, ale_cnt, clock_output_primary} = '0;
        {address_enable_strap, show_read_strap, ext_ready} = 3'b111;
        hsize = 3'b010;
        intmem_data = 16'ha5c3;
        do_reset;
        xfer(1'b0, xbus_pkg::CFG_OFS, 32'h0);
        chk(q, 32'h3c5a);
        xfer(1'b0, xbus_pkg::STATUS_OFS, 32'h0);
        chk(q & 32'hc, 32'hc);
        xfer(1'b1, xbus_pkg::CTRL_OFS, 32'h8);
        xfer(1'b0, xbus_pkg::STATUS_OFS, 32'h0);
        chk(q & 32'h10, 32'h0);
        xfer(1'b1, xbus_pkg::CTRL_OFS, 32'h0);
        xfer(1'b1, xbus_pkg::WDATA_OFS, 32'hbeef);
        run_cmd(WR | BB);
        chk(pm_u.mem[5], 32'hbeef);
        xfer(1'b1, xbus_pkg::WDATA_OFS, 32'h1122);
        run_cmd(WR | LO | 32'h5);
        chk(pm_u.mem[5], 32'hbe22);
        ext_ready <= 1'b0;
        xfer(1'b1, xbus_pkg::CMD_OFS, BB);
        repeat (10) @(posedge hclk);
        xfer(1'b0, xbus_pkg::STATUS_OFS, 32'h0);
        chk(q & 32'h1, 32'h1);
        ext_ready <= 1'b1;
        run_cmd(BB);
        xfer(1'b0, xbus_pkg::RDATA_OFS, 32'h0);
        chk(q, 32'hbe22);
        xfer(1'b1, xbus_pkg::CTRL_OFS, 32'h2);
        ale_cnt = 0;
        run_cmd(LS | BB);
        chk(ale_cnt, 32'h0);
        xfer(1'b1, xbus_pkg::CTRL_OFS, 32'h1);
        run_cmd(IM | BB);
        bus_hold <= 1'b1;
        repeat (4) @(posedge hclk);
        chk({nonmux_oe_n, shared_lo_oe_n, shared_hi_oe_n}, 32'h7);
        bus_hold <= 1'b0;
        address_enable_strap <= 1'b0;
        do_reset;
        xfer(1'b1, xbus_pkg::CTRL_OFS, 32'ha);
        xfer(1'b0, xbus_pkg::STATUS_OFS, 32'h0);
        chk(q & 32'h10, 32'h10);
        ale_cnt = 0;
        run_cmd(LS | BB);
        chk(ale_cnt, 32'h1);
        report_and_stop;
    end
endmodule : testbench
